/* File: hw/prc_params.svh */
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PRC_OFF_CTRL 8'h48
`define PRC_OFF_STATUS 8'h4c
`define PRC_OFF_SCRATCH 8'h50

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PRC_FW_RST_BIT 0
`define PRC_HOST_SEL_BIT 1
`define PRC_ST_PLAT_BIT 0
`define PRC_ST_PWRGD_BIT 1
`define PRC_ST_LPC_BIT 2
`define PRC_ST_ESPI_BIT 3
`define PRC_ST_POR_BIT 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PRC_FW_RST_RST 1'h1
`define PRC_HOST_SEL_RST 1'h0
`define PRC_SCRATCH_RST 32'h0000_0000
`define PRC_RDATA_RST 32'h0000_0000

`endif

/* File: hw/prc_pkg.sv */
// ----------------------------------------------------------------------------
// Types shared by the platform reset control block
// ----------------------------------------------------------------------------
package prc_pkg;

  // Control register fields, bit 1 down to bit 0
  typedef struct packed {
    logic host_sel;
    logic fw_reset;
  } prc_ctrl_t;

  // Reset inputs as seen by the block
  typedef struct packed {
    logic por_n;
    logic espi_n;
    logic lpc_n;
    logic pwrgd;
  } prc_rst_in_t;

endpackage : prc_pkg

/* File: hw/prc_top.sv */
// Overview of operation
// - Control bit 1 selects host reset source: 0 LPC pin, 1 eSPI; resets 0.
// - External reset output pin always mirrors the internal platform reset.
// - Main power good low holds platform reset asserted, firmware bit ignored.
// - Firmware reset bit set always asserts the internal platform reset.
// - Firmware bit is read/write and loads 1 on power-on reset.
// - Platform reset clears only selected registers, not all block logic.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "prc_params.svh"

module prc_top
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic power_on_reset_n,
  input wire logic main_power_good,
  input wire logic lpc_reset_n,
  input wire logic espi_reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic platform_reset_n,
  output logic host_reset_out_pin
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  prc_pkg::prc_ctrl_t ctrl_ff;
  prc_pkg::prc_ctrl_t nxt_ctrl;
  prc_pkg::prc_rst_in_t rst_in;
  logic platform_reset_n_ff;
  logic nxt_platform_reset_n;
  logic host_reset_out_pin_ff;
  logic nxt_host_reset_out_pin;
  logic [31:0] scratch_ff;
  logic [31:0] nxt_scratch;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic ctrl_clear;
  logic host_rst_n;
  logic wr_ctrl;
  logic wr_scratch;

  assign rst_in = {power_on_reset_n, espi_reset_n, lpc_reset_n, main_power_good};

  assign ctrl_clear = sys_rst | ~rst_in.por_n;
  assign wr_ctrl = reg_wr && (reg_addr == `PRC_OFF_CTRL);
  assign wr_scratch = reg_wr && (reg_addr == `PRC_OFF_SCRATCH);

  // --------------------------------------------------------------------------
  // Host reset source selection
  // --------------------------------------------------------------------------
  // source mux
  assign host_rst_n = ctrl_ff.host_sel ? rst_in.espi_n : rst_in.lpc_n;

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_clear)
    begin
      nxt_ctrl.fw_reset = `PRC_FW_RST_RST;
      nxt_ctrl.host_sel = `PRC_HOST_SEL_RST;
    end
    else if (wr_ctrl)
    begin
      nxt_ctrl.fw_reset = reg_wdata[`PRC_FW_RST_BIT];
      nxt_ctrl.host_sel = reg_wdata[`PRC_HOST_SEL_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    ctrl_ff <= nxt_ctrl;
  end

  // --------------------------------------------------------------------------
  // Platform reset and output pin
  // --------------------------------------------------------------------------
  always_comb
  begin
    if (sys_rst)
    begin
      nxt_platform_reset_n = 1'h0;
    end
    else if (!rst_in.pwrgd)
    begin
      nxt_platform_reset_n = 1'h0;
    end
    else if (ctrl_ff.fw_reset)
    begin
      nxt_platform_reset_n = 1'h0;
    end
    else
    begin
      nxt_platform_reset_n = rst_in.por_n & host_rst_n;
    end
    nxt_host_reset_out_pin = nxt_platform_reset_n;
  end

  always_ff @(posedge ref_clk)
  begin
    platform_reset_n_ff <= nxt_platform_reset_n;
    host_reset_out_pin_ff <= nxt_host_reset_out_pin;
  end

  assign platform_reset_n = platform_reset_n_ff;
  assign host_reset_out_pin = host_reset_out_pin_ff;

  // --------------------------------------------------------------------------
  // Scratch register cleared by platform reset
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_scratch = scratch_ff;
    if (sys_rst || !platform_reset_n_ff)
    begin
      nxt_scratch = `PRC_SCRATCH_RST;
    end
    else if (wr_scratch)
    begin
      nxt_scratch = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    scratch_ff <= nxt_scratch;
  end

  // --------------------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = `PRC_RDATA_RST;
    if (!sys_rst && reg_rd)
    begin
      case (reg_addr)
        `PRC_OFF_CTRL:
        begin
          nxt_rdata[`PRC_FW_RST_BIT] = ctrl_ff.fw_reset;
          nxt_rdata[`PRC_HOST_SEL_BIT] = ctrl_ff.host_sel;
        end
        `PRC_OFF_STATUS:
        begin
          nxt_rdata[`PRC_ST_PLAT_BIT] = platform_reset_n_ff;
          nxt_rdata[`PRC_ST_PWRGD_BIT] = rst_in.pwrgd;
          nxt_rdata[`PRC_ST_LPC_BIT] = rst_in.lpc_n;
          nxt_rdata[`PRC_ST_ESPI_BIT] = rst_in.espi_n;
          nxt_rdata[`PRC_ST_POR_BIT] = rst_in.por_n;
        end
        `PRC_OFF_SCRATCH:
        begin
          nxt_rdata = scratch_ff;
        end
        default:
        begin
          nxt_rdata = `PRC_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // eSPI source honoured
  property p_espi_sel;
    @(posedge ref_clk) disable iff (sys_rst)
    (ctrl_ff.host_sel && !rst_in.espi_n) |=> !platform_reset_n_ff;
  endproperty
  a_espi_sel: assert property (p_espi_sel)
    else $error("eSPI reset selected but platform reset released");

  property p_lpc_sel;
    @(posedge ref_clk) disable iff (sys_rst)
    (!ctrl_ff.host_sel && !rst_in.lpc_n) |=> !platform_reset_n_ff;
  endproperty
  a_lpc_sel: assert property (p_lpc_sel)
    else $error("LPC reset selected but platform reset released");

  property p_pin_mirror;
    @(posedge ref_clk) disable iff (sys_rst)
    host_reset_out_pin_ff == platform_reset_n_ff;
  endproperty
  a_pin_mirror: assert property (p_pin_mirror)
    else $error("reset output pin differs from platform reset");

  property p_pwrgd_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    !rst_in.pwrgd |=> !platform_reset_n_ff;
  endproperty
  a_pwrgd_hold: assert property (p_pwrgd_hold)
    else $error("platform reset released without main power good");

  property p_release_cause;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(platform_reset_n_ff) |->
      $past(rst_in.por_n && rst_in.pwrgd && host_rst_n && !ctrl_ff.fw_reset);
  endproperty
  a_release_cause: assert property (p_release_cause)
    else $error("platform reset released with a reset cause active");

  property p_release_due;
    @(posedge ref_clk) disable iff (sys_rst)
    (rst_in.por_n && rst_in.pwrgd && host_rst_n && !ctrl_ff.fw_reset)
      |=> platform_reset_n_ff;
  endproperty
  a_release_due: assert property (p_release_due)
    else $error("platform reset held with no cause");

  property p_fw_assert;
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_ctrl && reg_wdata[`PRC_FW_RST_BIT] && rst_in.por_n)
      |=> ctrl_ff.fw_reset ##1 !platform_reset_n_ff;
  endproperty
  a_fw_assert: assert property (p_fw_assert)
    else $error("firmware reset bit did not assert platform reset");

  property p_por_default;
    @(posedge ref_clk) disable iff (sys_rst)
    !rst_in.por_n |=> (ctrl_ff.fw_reset && !ctrl_ff.host_sel);
  endproperty
  a_por_default: assert property (p_por_default)
    else $error("control register not at default after power-on reset");

  property p_ctrl_read;
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `PRC_OFF_CTRL) |=>
      (reg_rdata[1:0] == $past(ctrl_ff) && reg_rdata[31:2] == 30'h0);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control register read back wrong value");

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside the read answer cycle");

  property p_status_read;
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `PRC_OFF_STATUS) |=>
      reg_rdata == {27'h0, $past(rst_in), $past(platform_reset_n_ff)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status register read back wrong value");

  property p_scratch_write;
    @(posedge ref_clk) disable iff (sys_rst)
    (wr_scratch && platform_reset_n_ff) |=>
      scratch_ff == $past(reg_wdata);
  endproperty
  a_scratch_write: assert property (p_scratch_write)
    else $error("scratch register did not take the written value");

  property p_scratch_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    !platform_reset_n_ff |=> scratch_ff == `PRC_SCRATCH_RST;
  endproperty
  a_scratch_clear: assert property (p_scratch_clear)
    else $error("scratch register survived platform reset");

endmodule : prc_top

`default_nettype wire

/* File: verification/prc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Host side reset sources and power rails
// ----------------------------------------------------------------------------
module prc_host_model
(
  input wire logic ref_clk,
  output logic power_on_reset_n,
  output logic main_power_good,
  output logic lpc_reset_n,
  output logic espi_reset_n
);
  initial
  begin
    power_on_reset_n = 1'h1;
    main_power_good = 1'h1;
    lpc_reset_n = 1'h1;
    espi_reset_n = 1'h1;
  end

  // Levels change just after a clock edge
  task drive(input logic por, input logic pg, input logic lpc, input logic espi);
    @(posedge ref_clk);
    power_on_reset_n <= por;
    main_power_good <= pg;
    lpc_reset_n <= lpc;
    espi_reset_n <= espi;
  endtask : drive
endmodule : prc_host_model

`default_nettype wire

/* File: verification/prc_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "prc_params.svh"

module prc_top_bench;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic por_n, pg, lpc_n, espi_n;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic platform_reset_n, host_reset_out_pin;
  logic [31:0] rdat;
  int bad_count = 0;
  int n_compared = 0;
  localparam logic [31:0] CTRL_RST = {30'h0, `PRC_HOST_SEL_RST, `PRC_FW_RST_RST};

  prc_host_model host (.ref_clk(ref_clk), .power_on_reset_n(por_n),
    .main_power_good(pg), .lpc_reset_n(lpc_n), .espi_reset_n(espi_n));

  prc_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .power_on_reset_n(por_n),
    .main_power_good(pg), .lpc_reset_n(lpc_n), .espi_reset_n(espi_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .platform_reset_n(platform_reset_n),
    .host_reset_out_pin(host_reset_out_pin));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 rdat = reg_rdata;
  endtask : rd

  // Lets the control flop and the output flop both land
  task chk_rst(input logic exp);
    repeat (3) @(posedge ref_clk);
    #1 chk("platform_reset_n", {31'h0, platform_reset_n}, {31'h0, exp});
    chk("host_reset_out_pin", {31'h0, host_reset_out_pin}, {31'h0, exp});
  endtask : chk_rst

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_reset_vals;
    rd(`PRC_OFF_CTRL);
    chk("ctrl reset", rdat, CTRL_RST);
    chk_rst(1'h0);
  endtask : t_reset_vals

  task t_release;
    wr(`PRC_OFF_CTRL, 32'h0);
    chk_rst(1'h1);
    rd(`PRC_OFF_STATUS);
    chk("status", rdat, 32'h0000_001f);
  endtask : t_release

  task t_select;
    host.drive(1'h1, 1'h1, 1'h0, 1'h1);
    chk_rst(1'h0);
    host.drive(1'h1, 1'h1, 1'h1, 1'h0);
    chk_rst(1'h1);
    wr(`PRC_OFF_CTRL, 32'h2);
    chk_rst(1'h0);
    host.drive(1'h1, 1'h1, 1'h0, 1'h1);
    chk_rst(1'h1);
    host.drive(1'h1, 1'h1, 1'h1, 1'h1);
  endtask : t_select

  task t_power;
    host.drive(1'h1, 1'h0, 1'h1, 1'h1);
    chk_rst(1'h0);
    host.drive(1'h1, 1'h1, 1'h1, 1'h1);
    chk_rst(1'h1);
    host.drive(1'h0, 1'h1, 1'h1, 1'h1);
    chk_rst(1'h0);
    host.drive(1'h1, 1'h1, 1'h1, 1'h1);
    chk_rst(1'h0);
    rd(`PRC_OFF_CTRL);
    chk("ctrl after por", rdat, CTRL_RST);
  endtask : t_power

  task t_scratch;
    wr(`PRC_OFF_CTRL, 32'h0);
    chk_rst(1'h1);
    wr(`PRC_OFF_SCRATCH, 32'ha5a5_5a5a);
    rd(`PRC_OFF_SCRATCH);
    chk("scratch", rdat, 32'ha5a5_5a5a);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10);
    chk("unmapped", rdat, 32'h0);
    wr(`PRC_OFF_CTRL, 32'h1);
    chk_rst(1'h0);
    rd(`PRC_OFF_SCRATCH);
    chk("scratch cleared", rdat, `PRC_SCRATCH_RST);
  endtask : t_scratch

  task conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // --------------------------------------------------------------------------
  // Clock, sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_reset_vals();
    t_release();
    t_select();
    t_power();
    t_scratch();
    conclude();
  end

  initial
  begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule : prc_top_bench

`default_nettype wire
